// *** logic/rif_pkg.sv ***
/*
  Constants for the receive information flag bank: register offsets,
  bit positions, detector thresholds and timing figures.
  Assumes a single recovered-clock domain running at 250 MHz.
*/
package rif_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] RIF_OFS_EVENT = 8'h08;
  localparam logic [7:0] RIF_OFS_LEVEL = 8'h09;

  // event register bit positions
  localparam int RIF_B_ZERO_RUN = 7;
  localparam int RIF_B_LONG_ZERO = 6;
  localparam int RIF_B_SUB_WORD = 5;
  localparam int RIF_B_CARRIER_CLR = 4;
  localparam int RIF_B_ONES_CLR = 3;
  localparam int RIF_B_JITTER_TRIP = 2;

  // level register bit positions
  localparam int RIF_B_LEVEL_LSB = 4;
  localparam int RIF_B_LOOP_ACTIVE = 1;
  localparam int RIF_B_SECOND = 0;

  // values after reset
  localparam logic [7:0] RIF_RST_BYTE = 8'h00;
  localparam logic [3:0] RIF_RST_LEVEL = 4'h0;

  // ------------------------------------------------------------
  // detector thresholds
  // ------------------------------------------------------------
  localparam logic [4:0] RIF_ZERO_RUN_E1 = 5'h04;
  localparam logic [4:0] RIF_ZERO_RUN_T1 = 5'h08;
  localparam logic [4:0] RIF_LONG_ZERO_RUN = 5'h10;
  localparam logic [4:0] RIF_RUN_MAX = 5'h1f;
  // zeros before a violation that mark a substitution word
  localparam logic [4:0] RIF_SUB_ZEROS_E1 = 5'h02;
  localparam logic [4:0] RIF_SUB_ZEROS_T1 = 5'h03;
  localparam logic [7:0] RIF_JITTER_MARGIN = 8'h04;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint RIF_CLK_HZ = 250_000_000;
  localparam longint RIF_SEC_TIME_S = 1;
  localparam longint RIF_LOOP_TIME_S = 5;
  localparam int unsigned RIF_SEC_CYCLES = 32'(RIF_CLK_HZ * RIF_SEC_TIME_S);
  localparam int unsigned RIF_LOOP_CYCLES = 32'(RIF_CLK_HZ * RIF_LOOP_TIME_S);

  typedef enum logic [0:0] {
    RIF_LOOP_OFF = 1'b0,
    RIF_LOOP_ON = 1'b1
  } rif_loop_t;

endpackage

// *** logic/rif_receive_info.sv ***
/*
  Receive information flag bank: a clear-on-read event byte and a
  real-time level/loopback byte with a clear-on-read second flag, read through the parallel
  register port.
  Assumes all inputs come from receiver logic on ref_clk (the
  recovered clock); alarm detectors and loop code detectors are
  outside and deliver levels.
*/
// Operation
// - zero run of 4 (E1) or 8 (T1) sets a flag; read clears it
// - zero run of 16 or more sets a flag; read clears it
// - substitution word seen sets a flag, decoding on or off; read clears
// - carrier loss alarm clearing sets a flag; read clears it
// - unframed all-ones alarm clearing sets a flag; read clears it
// - jitter FIFO within 4 bits of its limit sets a flag; read clears it
// - unassigned bits carry no meaning; host ignores them
// - 4-bit receive level code shown live in upper nibble, 2.5 dB steps
// - loopback indication rises after loop-up code held 5 seconds
// - loopback indication falls after loop-down code held 5 seconds, or at once when automatic loopback disabled
// - loopback indication held low while automatic loopback disabled
// - one-second flag set at each second of clock count; read clears
// - carrier loss clear criterion judged by the alarm detector
// - all-ones clear criterion judged by the alarm detector
`timescale 1ns/1ps
module rif_receive_info
#(
  parameter int unsigned SEC_CYCLES = rif_pkg::RIF_SEC_CYCLES,
  parameter int unsigned LOOP_CYCLES = rif_pkg::RIF_LOOP_CYCLES
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // receive line, one strobe per bit
  input wire logic rx_bit_en,
  input wire logic rx_pos,
  input wire logic rx_neg,
  // controls
  input wire logic line_standard_select,
  input wire logic remote_loop_auto,
  // alarm detectors
  input wire logic carrier_loss_alarm,
  input wire logic unframed_ones_alarm,
  // jitter attenuator fill
  input wire logic [7:0] jitter_fill,
  input wire logic [7:0] jitter_limit,
  // level and loop code detectors
  input wire logic [3:0] rx_level_code,
  input wire logic loop_up_det,
  input wire logic loop_down_det,
  // real-time indication
  output logic auto_remote_loop_active_q
);
  import rif_pkg::*;

  // ------------------------------------------------------------
  // line observation
  // ------------------------------------------------------------
  logic [4:0] zero_run_q;
  logic last_pol_q;
  logic rx_mark;
  logic rx_zero;
  logic violation;
  logic [4:0] run_thr;
  logic [4:0] sub_zeros;
  logic [5:0] run_next;
  logic set_zero_run;
  logic set_long_zero;
  logic set_sub_word;

  assign rx_mark = rx_pos | rx_neg;
  assign rx_zero = rx_bit_en & ~rx_mark;
  assign violation = rx_bit_en & rx_mark & (rx_pos == last_pol_q);
  assign run_thr = line_standard_select ? RIF_ZERO_RUN_T1 : RIF_ZERO_RUN_E1;
  assign sub_zeros = line_standard_select ? RIF_SUB_ZEROS_T1 : RIF_SUB_ZEROS_E1;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      zero_run_q <= 5'h0_0;
    end
    else if (rx_bit_en)
    begin
      if (rx_mark)
      begin
        zero_run_q <= 5'h0_0;
      end
      else if (zero_run_q != RIF_RUN_MAX)
      begin
        zero_run_q <= zero_run_q + 5'h0_1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_pol_q <= 1'b0;
    end
    else if (rx_bit_en & rx_mark)
    begin
      last_pol_q <= rx_pos;
    end
  end

  // run length including this zero, one bit wider so a saturated run cannot wrap
  assign run_next = {1'b0, zero_run_q} + 6'h01;
  assign set_zero_run = rx_zero & (run_next >= {1'b0, run_thr});
  assign set_long_zero = rx_zero & (run_next >= {1'b0, RIF_LONG_ZERO_RUN});
  // violation after zeros, independent of decoder mode
  assign set_sub_word = violation & (zero_run_q >= sub_zeros);

  // ------------------------------------------------------------
  // alarm edges and jitter trip
  // ------------------------------------------------------------
  logic carrier_q;
  logic ones_q;
  logic set_carrier_clr;
  logic set_ones_clr;
  logic set_jitter;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      carrier_q <= 1'b0;
      ones_q <= 1'b0;
    end
    else
    begin
      carrier_q <= carrier_loss_alarm;
      ones_q <= unframed_ones_alarm;
    end
  end

  // alarm has met its clear criterion
  assign set_carrier_clr = carrier_q & ~carrier_loss_alarm;
  assign set_ones_clr = ones_q & ~unframed_ones_alarm;
  // near full or near empty
  // nine-bit sum so a fill close to 255 cannot wrap past the limit
  assign set_jitter = (({1'b0, jitter_fill} + {1'b0, RIF_JITTER_MARGIN})
                       >= {1'b0, jitter_limit})
                    | (jitter_fill <= RIF_JITTER_MARGIN);

  // ------------------------------------------------------------
  // one-second timer
  // ------------------------------------------------------------
  logic [31:0] sec_cnt_q;
  logic sec_tick;

  assign sec_tick = (sec_cnt_q == SEC_CYCLES - 32'h0000_0001);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sec_cnt_q <= 32'h0000_0000;
    end
    else if (sec_tick)
    begin
      sec_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // automatic remote loopback
  // ------------------------------------------------------------
  rif_loop_t loop_q;
  logic [31:0] hold_cnt_q;
  logic hold_cond;
  logic hold_done;

  assign hold_cond = (loop_q == RIF_LOOP_OFF) ? loop_up_det : loop_down_det;
  assign hold_done = hold_cond & (hold_cnt_q == LOOP_CYCLES - 32'h0000_0001);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_cnt_q <= 32'h0000_0000;
    end
    else if (!remote_loop_auto || !hold_cond || hold_done)
    begin
      hold_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      loop_q <= RIF_LOOP_OFF;
    end
    else if (!remote_loop_auto)
    begin
      loop_q <= RIF_LOOP_OFF;
    end
    else
    begin
      case (loop_q)
        RIF_LOOP_OFF: if (hold_done) loop_q <= RIF_LOOP_ON;
        RIF_LOOP_ON: if (hold_done) loop_q <= RIF_LOOP_OFF;
        default: loop_q <= RIF_LOOP_OFF;
      endcase
    end
  end

  assign auto_remote_loop_active_q = loop_q[0];

  // ------------------------------------------------------------
  // latched flags and register read
  // ------------------------------------------------------------
  logic [7:0] event_q;
  logic sec_flag_q;
  logic [3:0] level_q;
  logic [7:0] event_set;
  logic rd_event;
  logic rd_level;

  assign event_set = {set_zero_run, set_long_zero, set_sub_word,
                      set_carrier_clr, set_ones_clr, set_jitter, 2'b00};
  assign rd_event = reg_rd & (reg_addr == RIF_OFS_EVENT);
  assign rd_level = reg_rd & (reg_addr == RIF_OFS_LEVEL);

  // set wins over the clearing read
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      event_q <= RIF_RST_BYTE;
      sec_flag_q <= 1'b0;
    end
    else
    begin
      event_q <= (rd_event ? 8'h0_0 : event_q) | event_set;
      sec_flag_q <= (rd_level ? 1'b0 : sec_flag_q) | sec_tick;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      level_q <= RIF_RST_LEVEL;
    end
    else
    begin
      level_q <= rx_level_code;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata_q <= RIF_RST_BYTE;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (rd_event)
      begin
        reg_rdata_q <= event_q;
      end
      else if (rd_level)
      begin
        reg_rdata_q <= {level_q, 2'b00, auto_remote_loop_active_q, sec_flag_q};
      end
      else if (reg_rd)
      begin
        reg_rdata_q <= RIF_RST_BYTE;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_ZERO_RUN: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rx_zero && zero_run_q >= (line_standard_select ? RIF_ZERO_RUN_T1 : RIF_ZERO_RUN_E1) - 5'h01)
    |=> event_q[RIF_B_ZERO_RUN]) else $error("zero run flag missed");
  AST_LONG_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rx_zero && zero_run_q >= 5'h0_f) |=> event_q[RIF_B_LONG_ZERO])
    else $error("long zero flag missed");
  AST_SUB_WORD: assert property (@(posedge ref_clk) disable iff (!nrst)
    (violation && zero_run_q >= sub_zeros) |=> event_q[RIF_B_SUB_WORD])
    else $error("substitution flag missed");
  AST_CARRIER: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(carrier_loss_alarm) |-> ##1 event_q[RIF_B_CARRIER_CLR])
    else $error("carrier clear flag missed");
  AST_ONES: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(unframed_ones_alarm) |-> ##1 event_q[RIF_B_ONES_CLR])
    else $error("all-ones clear flag missed");
  AST_JITTER: assert property (@(posedge ref_clk) disable iff (!nrst)
    (jitter_fill <= RIF_JITTER_MARGIN) |=> event_q[RIF_B_JITTER_TRIP])
    else $error("jitter trip flag missed");
  AST_LEVEL: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_level ##1 1'b1 |-> reg_rdata_q[7:4] == $past(rx_level_code, 2))
    else $error("level code wrong");
  AST_LOOP_OFF: assert property (@(posedge ref_clk) disable iff (!nrst)
    !remote_loop_auto |=> !auto_remote_loop_active_q)
    else $error("loopback not forced low");
  AST_LOOP_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
    (auto_remote_loop_active_q && !loop_down_det && remote_loop_auto)
    |=> auto_remote_loop_active_q) else $error("loopback dropped early");
  AST_SECOND: assert property (@(posedge ref_clk) disable iff (!nrst)
    sec_tick |=> sec_flag_q ##0 sec_cnt_q == 32'h0000_0000)
    else $error("second flag missed");
  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_event |=> ((event_q & $past(event_set)) == $past(event_set)) && reg_rvalid_q)
    else $error("event lost on read");
endmodule

// *** verification/rif_host_model.sv ***
/*
  Host processor model: one-cycle reads on the register port.
  Assumes ref_clk drives the bank; changes land 1 ns after edges.
*/
`timescale 1ns/1ps
module rif_host_model
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic read(input logic [7:0] addr);
    @(posedge ref_clk);
    #1;
    reg_addr = addr;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_addr = ~addr;
    reg_rd = 1'b0;
  endtask
endmodule

// *** verification/testbench.sv ***
/*
  Self-checking bench for the receive information bank.
  Assumes rif_host_model issues reads; second and loop counts shortened.
*/
`timescale 1ns/1ps
module testbench;
  import rif_pkg::*;
  localparam int unsigned SEC_N = 400;
  localparam int unsigned LOOP_N = 40;
  logic ref_clk, nrst, reg_rd, reg_rvalid_q, rx_bit_en, rx_pos, rx_neg;
  logic line_standard_select, remote_loop_auto, carrier_loss_alarm, unframed_ones_alarm;
  logic loop_up_det, loop_down_det, auto_remote_loop_active_q, last_pos, loop_e;
  logic [7:0] reg_addr, reg_rdata_q, jitter_fill, jitter_limit, lim;
  logic [3:0] rx_level_code;
  logic [15:0] exp_e;
  logic [15:0] exp_q[$];
  logic [31:0] rng = 32'h0000_0a69;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int th;
  int n;

  rif_receive_info #(.SEC_CYCLES(SEC_N), .LOOP_CYCLES(LOOP_N)) i_dut (
    .ref_clk, .nrst, .reg_addr, .reg_rd, .reg_rdata_q, .reg_rvalid_q, .rx_bit_en, .rx_pos,
    .rx_neg, .line_standard_select, .remote_loop_auto, .carrier_loss_alarm,
    .unframed_ones_alarm, .jitter_fill, .jitter_limit, .rx_level_code, .loop_up_det,
    .loop_down_det, .auto_remote_loop_active_q);
  rif_host_model i_host (.ref_clk, .reg_addr, .reg_rd);

  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= nrst ? cyc + 1 : 0;

  // --------------------
  // helpers
  // --------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    i_host.read(a);
  endtask

  task automatic ev(input logic [7:0] e);
    rd(RIF_OFS_EVENT, e, 8'hfc);
  endtask

  task automatic lv();
    rd(RIF_OFS_LEVEL, {rx_level_code, 2'b00, loop_e, 1'b0}, 8'hf2);
  endtask

  task automatic lp(input string w, input logic e);
    check(w, {7'h00, auto_remote_loop_active_q}, {7'h00, e});
  endtask

  task automatic send(input int zeros, input logic viol);
    logic p;
    p = viol ? last_pos : ~last_pos;
    repeat (zeros)
    begin
      tick(1);
      {rx_bit_en, rx_pos, rx_neg} = 3'b100;
    end
    tick(1);
    {rx_bit_en, rx_pos, rx_neg} = {1'b1, p, ~p};
    last_pos = p;
    tick(1);
    rx_bit_en = 1'b0;
  endtask

  always @(negedge ref_clk)
    if (reg_rvalid_q === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stray read", 8'h00, 8'hff);
      else
      begin
        exp_e = exp_q.pop_front();
        check("read data", reg_rdata_q & exp_e[15:8], exp_e[7:0] & exp_e[15:8]);
      end
    end

  initial
  begin
    #40000;
    failures++;
    wrap_up();
  end

  // --------------------
  // scenarios
  // --------------------
  initial
  begin
    {nrst, rx_bit_en, rx_pos, rx_neg, line_standard_select, remote_loop_auto} = 6'h00;
    {carrier_loss_alarm, unframed_ones_alarm, loop_up_det, loop_down_det} = 4'h0;
    {last_pos, loop_e} = 2'h0;
    {jitter_fill, jitter_limit, rx_level_code} = {8'h64, 8'hc8, 4'h0};
    tick(2);
    nrst = 1'b1;
    ev(8'h00);
    lv();
    rd(8'h07, 8'h00, 8'hff);
    send(0, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      line_standard_select = s[0];
      th = s ? 8 : 4;
      for (int i = 0; i < 4; i++)
      begin
        n = (i < 2) ? th - 1 + i : 13 + i;
        send(n, 1'b0);
        ev({n >= th, n >= 16, 6'h00});
        ev(8'h00);
      end
      th = s ? 3 : 2;
      send(th - 1, 1'b1);
      ev(8'h00);
      send(th, 1'b1);
      ev(8'h20);
      ev(8'h00);
    end
    {carrier_loss_alarm, unframed_ones_alarm} = 2'b11;
    tick(2);
    ev(8'h00);
    fork
      rd(RIF_OFS_EVENT, 8'h00, 8'h00);
      begin
        tick(1);
        carrier_loss_alarm = 1'b0;
      end
    join
    ev(8'h10);
    unframed_ones_alarm = 1'b0;
    tick(2);
    ev(8'h08);
    repeat (4)
    begin
      lim = 8'(64 + xs() % 192);
      {jitter_limit, jitter_fill} = {lim, 8'(5 + xs() % (lim - 9))};
      tick(2);
      ev(8'h00);
      jitter_fill = lim - 8'h05;
      tick(2);
      ev(8'h00);
      jitter_fill = lim - 8'h04;
      tick(1);
      jitter_fill = lim - 8'h05;
      ev(8'h04);
    end
    jitter_fill = RIF_JITTER_MARGIN;
    tick(1);
    jitter_fill = lim - 8'h05;
    ev(8'h04);
    ev(8'h00);
    for (int c = 0; c < 16; c++)
    begin
      rx_level_code = 4'(c);
      tick(1);
      lv();
    end
    loop_up_det = 1'b1;
    tick(LOOP_N + 5);
    lp("loop while disabled", 1'b0);
    loop_up_det = 1'b0;
    remote_loop_auto = 1'b1;
    tick(2);
    loop_up_det = 1'b1;
    tick(LOOP_N - 2);
    lp("loop early", 1'b0);
    tick(4);
    lp("loop on", 1'b1);
    loop_e = 1'b1;
    lv();
    {loop_up_det, loop_down_det} = 2'b01;
    tick(LOOP_N - 2);
    lp("loop held", 1'b1);
    tick(4);
    lp("loop off", 1'b0);
    loop_e = 1'b0;
    lv();
    {loop_up_det, loop_down_det} = 2'b10;
    tick(LOOP_N + 4);
    lp("loop on again", 1'b1);
    remote_loop_auto = 1'b0;
    tick(1);
    lp("loop disabled", 1'b0);
    while (cyc % SEC_N != SEC_N / 2)
      tick(1);
    rd(RIF_OFS_LEVEL, 8'h00, 8'h00);
    rd(RIF_OFS_LEVEL, 8'h00, 8'h01);
    tick(SEC_N);
    rd(RIF_OFS_LEVEL, 8'h01, 8'h01);
    rd(RIF_OFS_LEVEL, 8'h00, 8'h01);
    tick(4);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule
